// ==== inc/smsc_pkg.sv ====
// constants, types and helpers for the stop mode standby controller
// Notes on behaviour
// - timer51 runs only on its external input
// - interval timer a needs running timer50 output
// - interval timer b needs low-speed clock choices
// - watch, clock out, lcd need sub clock
// - watchdog loses clock when oscillator stoppable
// - async serials need running timer50 output
// - clocked serials need external serial clock
// - low-speed oscillator keeps state through stop
// - amplifier high, internal clock: hold cpu clock
// - amplifier high, external clock: hold 160 clocks
// - post-release wait 8 vectored, 2 otherwise
// - unmasked interrupt request releases stop
// - after stabilization vector or next instruction
// - only interrupt or reset ends stop
// - reset ends stop, restart at reset vector
// - stop entered only from main system clock
// - pending unmasked interrupt: skip stop, go straight to stabilization
package smsc_pkg;

  localparam int IRQ_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 17;

  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W = 3;
  localparam int CTRL_AMPLIFIER_HIGH_SETTING_BIT = 3;
  localparam int CTRL_LSOSC_BIT = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h10;
  localparam logic [DATA_W-1:0] RD_NONE = 8'h00;
  localparam int STAT_STANDBY_BIT = 0;
  localparam int STAT_STAB_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_VEC_BIT = 3;
  localparam int STAT_DONE_BIT = 4;

  // timing
  localparam int CLK_MHZ = 40;
  localparam int HOLD_MIN_NS = 4060;
  localparam int HOLD_MAX_NS = 16120;
  localparam int HOLD_INT_CYC = (HOLD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_EXT_CLKS = 160;
  localparam int WAIT_VEC_CLKS = 8;
  localparam int WAIT_NEXT_CLKS = 2;
  localparam int NO_STAB_CYC = 1;

  // cpu clock sources
  localparam logic [1:0] SRC_INT_HIGH = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // interval timer b count clock codes on the low-speed clock
  localparam logic [2:0] ITB_SEL_LS = 3'h5;
  localparam logic [2:0] ITB_SEL_LS_D7 = 3'h6;
  localparam logic [2:0] ITB_SEL_LS_D9 = 3'h7;

  // peripheral enable indices
  localparam int PE_TIMER50 = 0;
  localparam int PE_TIMER51 = 1;
  localparam int PE_ITA = 2;
  localparam int PE_ITB = 3;
  localparam int PE_WATCH = 4;
  localparam int PE_CLKOUT = 5;
  localparam int PE_LCD = 6;
  localparam int PE_ASYNC_A = 7;
  localparam int PE_ASYNC_B = 8;
  localparam int PE_CSER_A = 9;
  localparam int PE_CSER_B = 10;
  localparam int PE_TWO_WIRE = 11;
  localparam int PE_ADC = 12;
  localparam int PE_N = 13;

  typedef enum logic [2:0] {
    ST_RUN, ST_STOP, ST_STAB, ST_HOLD, ST_WAIT
  } smsc_state_t;

  // cycle count to timer load value (timer counts n-1 down to zero)
  function automatic logic [CNT_W-1:0] smsc_load(input int n);
    int m;
    m = (n < 1) ? 0 : n - 1;
    return m[CNT_W-1:0];
  endfunction

endpackage

// ==== inc/smsc_wait_if.sv ====
// load and done handshake between sequencer and wait timer
interface smsc_wait_if;
  logic                        load;
  logic [smsc_pkg::CNT_W-1:0]  value;
  logic                        tick;
  logic                        done;
  modport ctrl (output load, output value, output tick, input done);
  modport cnt  (input load, input value, input tick, output done);
endinterface

// ==== rtl/smsc_wait_timer.sv ====
// down counter for stabilization, clock hold and post-release wait
module smsc_wait_timer (
  input  wire logic   clk,
  input  wire logic   rst,
  smsc_wait_if.cnt    w
);

  logic [smsc_pkg::CNT_W-1:0] cnt_q;
  logic                       busy_q;
  logic                       at_zero;

  assign at_zero = (cnt_q == '0);
  // kept free of load: load follows done, so a load term would loop
  assign w.done  = busy_q & at_zero;

  // reload wins over counting; tick lets the hold count external clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (w.load) begin
      cnt_q  <= w.value;
      busy_q <= 1'b1;
    end else if (busy_q & w.tick & ~at_zero) begin
      cnt_q  <= cnt_q - 1'b1;
    end
  end

endmodule

// ==== rtl/smsc_periph_gate.sv ====
// per-peripheral clock gate decode from standby and clock selections
module smsc_periph_gate (
  input  wire logic                       standby,
  input  wire logic                       t50_ext_sel,
  input  wire logic                       t50_running,
  input  wire logic                       t51_ext_sel,
  input  wire logic                       ita_t50_sel,
  input  wire logic [2:0]                 itb_sel,
  input  wire logic                       watch_sub_sel,
  input  wire logic                       clkout_sub_sel,
  input  wire logic                       lcd_sub_sel,
  input  wire logic                       async_a_t50_sel,
  input  wire logic                       async_b_t50_sel,
  input  wire logic                       cser_a_ext_sel,
  input  wire logic                       cser_b_ext_sel,
  output wire logic [smsc_pkg::PE_N-1:0]  en
);

  logic t50_live;
  logic itb_ls;

  // timer50 output only counts as a clock while timer50 itself runs
  assign t50_live = t50_running & t50_ext_sel;
  assign itb_ls = (itb_sel == smsc_pkg::ITB_SEL_LS) |
                  (itb_sel == smsc_pkg::ITB_SEL_LS_D7) |
                  (itb_sel == smsc_pkg::ITB_SEL_LS_D9);

  // outside standby everything runs; in standby each needs a live clock
  assign en[smsc_pkg::PE_TIMER50] = ~standby | t50_ext_sel;
  assign en[smsc_pkg::PE_TIMER51] = ~standby | t51_ext_sel;
  assign en[smsc_pkg::PE_ITA] = ~standby | (ita_t50_sel & t50_live);
  assign en[smsc_pkg::PE_ITB] = ~standby | itb_ls;
  assign en[smsc_pkg::PE_WATCH] = ~standby | watch_sub_sel;
  assign en[smsc_pkg::PE_CLKOUT] = ~standby | clkout_sub_sel;
  assign en[smsc_pkg::PE_LCD] = ~standby | lcd_sub_sel;
  assign en[smsc_pkg::PE_ASYNC_A] =
    ~standby | (async_a_t50_sel & t50_live);
  assign en[smsc_pkg::PE_ASYNC_B] =
    ~standby | (async_b_t50_sel & t50_live);
  assign en[smsc_pkg::PE_CSER_A] = ~standby | cser_a_ext_sel;
  assign en[smsc_pkg::PE_CSER_B] = ~standby | cser_b_ext_sel;
  assign en[smsc_pkg::PE_TWO_WIRE] = ~standby;
  assign en[smsc_pkg::PE_ADC] = ~standby;

endmodule

// ==== rtl/stop_mode_standby_control.sv ====
// stop mode sequencer: entry, release, stabilization, gating, registers
module stop_mode_standby_control #(
  parameter int STAB_CYC_0 = 2048,
  parameter int STAB_CYC_1 = 8192,
  parameter int STAB_CYC_2 = 16384,
  parameter int STAB_CYC_3 = 32768,
  parameter int STAB_CYC_4 = 65536
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [smsc_pkg::ADDR_W-1:0]   addr,
  input  wire logic [smsc_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [smsc_pkg::DATA_W-1:0]   rd_data_q,
  // cpu side
  input  wire logic                          stop_exec,
  input  wire logic                          cpu_on_main_clock,
  input  wire logic [1:0]                    cpu_clk_src,
  input  wire logic                          ext_clk_tick,
  input  wire logic                          int_enable,
  // interrupt logic
  input  wire logic [smsc_pkg::IRQ_W-1:0]    int_req,
  input  wire logic [smsc_pkg::IRQ_W-1:0]    int_mask,
  // option setting
  input  wire logic                          lsosc_sw_stoppable,
  // peripheral clock selections
  input  wire logic                          t50_ext_sel,
  input  wire logic                          t50_running,
  input  wire logic                          t51_ext_sel,
  input  wire logic                          ita_t50_sel,
  input  wire logic [2:0]                    itb_sel,
  input  wire logic                          watch_sub_sel,
  input  wire logic                          clkout_sub_sel,
  input  wire logic                          lcd_sub_sel,
  input  wire logic                          async_a_t50_sel,
  input  wire logic                          async_b_t50_sel,
  input  wire logic                          cser_a_ext_sel,
  input  wire logic                          cser_b_ext_sel,
  // gates and sequencing results
  output logic                               cpu_clk_en_q,
  output logic      [smsc_pkg::PE_N-1:0]     periph_en_q,
  output logic                               lsosc_en_q,
  output logic                               wdt_clk_en_q,
  output logic                               standby_q,
  output logic                               vector_req_q,
  output logic                               next_instr_q,
  output logic                               reset_vector_q
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  smsc_pkg::smsc_state_t       state_q;
  smsc_pkg::smsc_state_t       state_d;
  logic [smsc_pkg::DATA_W-1:0] ctrl_q;
  logic                        amplifier_high_setting_q;
  logic [1:0]                  src_q;
  logic [smsc_pkg::CTRL_SEL_W-1:0] sel_q;
  logic                        vec_q;
  logic                        stab_done_q;
  logic                        wake;
  logic                        enter_ok;
  logic                        need_hold;
  logic                        hold_ext;
  logic                        vec_d;
  logic                        leave_wait;
  logic                        standby_d;
  logic                        cpu_clk_en_d;
  logic                        lsosc_run_d;
  logic                        lsosc_en_d;
  logic                        wdt_clk_en_d;
  logic [smsc_pkg::CNT_W-1:0]  stab_val;
  logic [smsc_pkg::CNT_W-1:0]  hold_val;
  logic [smsc_pkg::CNT_W-1:0]  wait_val;
  logic [smsc_pkg::PE_N-1:0]   periph_en_d;
  logic                        ctrl_wr;
  logic                        stat_rd;
  logic                        ctrl_rd;
  logic [smsc_pkg::DATA_W-1:0] stat_word;
  logic [smsc_pkg::DATA_W-1:0] rd_data_d;

  smsc_wait_if wt ();

  ////////////////////////////////////////////////////////////////////////
  // release and entry conditions

  // any request with its mask clear wakes the sequencer
  assign wake = |(int_req & ~int_mask);
  // stop only taken from the main system clock
  assign enter_ok = stop_exec & cpu_on_main_clock;
  // amplifier hold applies only to the internal or external clock
  assign need_hold = amplifier_high_setting_q & ((src_q == smsc_pkg::SRC_INT_HIGH) |
                               (src_q == smsc_pkg::SRC_EXT));
  assign hold_ext = (src_q == smsc_pkg::SRC_EXT);
  // acknowledgement is decided when stabilization ends
  assign vec_d = (state_q == smsc_pkg::ST_STAB) ? int_enable : vec_q;
  assign leave_wait = (state_q == smsc_pkg::ST_WAIT) & wt.done;

  ////////////////////////////////////////////////////////////////////////
  // load values for the wait timer

  // stabilization selection as latched at stop entry
  always_comb begin
    case (sel_q)
      3'h0:    stab_val = smsc_pkg::smsc_load(STAB_CYC_0);
      3'h1:    stab_val = smsc_pkg::smsc_load(STAB_CYC_1);
      3'h2:    stab_val = smsc_pkg::smsc_load(STAB_CYC_2);
      3'h3:    stab_val = smsc_pkg::smsc_load(STAB_CYC_3);
      3'h4:    stab_val = smsc_pkg::smsc_load(STAB_CYC_4);
      default: stab_val = smsc_pkg::smsc_load(STAB_CYC_4);
    endcase
  end

  // internal clock held in clk cycles, external clock in its own edges
  assign hold_val = hold_ext ?
    smsc_pkg::smsc_load(smsc_pkg::HOLD_EXT_CLKS) :
    smsc_pkg::smsc_load(smsc_pkg::HOLD_INT_CYC);
  // shortest wait of each pair; the cpu clock runs during it
  assign wait_val = vec_d ?
    smsc_pkg::smsc_load(smsc_pkg::WAIT_VEC_CLKS) :
    smsc_pkg::smsc_load(smsc_pkg::WAIT_NEXT_CLKS);

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state

  // only a wake request leaves stop; reset is the async path
  always_comb begin
    state_d = state_q;
    case (state_q)
      smsc_pkg::ST_RUN: begin
        if (enter_ok) begin
          // pending request drops straight into stabilization
          state_d = wake ? smsc_pkg::ST_STAB :
                           smsc_pkg::ST_STOP;
        end
      end
      smsc_pkg::ST_STOP: begin
        if (wake) begin
          state_d = smsc_pkg::ST_STAB;
        end
      end
      smsc_pkg::ST_STAB: begin
        if (wt.done) begin
          state_d = need_hold ? smsc_pkg::ST_HOLD : smsc_pkg::ST_WAIT;
        end
      end
      smsc_pkg::ST_HOLD: begin
        if (wt.done) begin
          state_d = smsc_pkg::ST_WAIT;
        end
      end
      smsc_pkg::ST_WAIT: begin
        if (wt.done) begin
          state_d = smsc_pkg::ST_RUN;
        end
      end
      default: state_d = smsc_pkg::ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // wait timer control

  // load on every entry into a timed state
  assign wt.load = (state_d != state_q) &
                   ((state_d == smsc_pkg::ST_STAB) |
                    (state_d == smsc_pkg::ST_HOLD) |
                    (state_d == smsc_pkg::ST_WAIT));
  // stabilization is entered from run or stop, so use next-state values
  assign wt.value =
    (state_d == smsc_pkg::ST_STAB) ?
      stab_entry_val(state_q == smsc_pkg::ST_RUN, cpu_clk_src, src_q,
                     ctrl_q[smsc_pkg::CTRL_SEL_LSB +: smsc_pkg::CTRL_SEL_W],
                     stab_val) :
    (state_d == smsc_pkg::ST_HOLD) ? hold_val : wait_val;
  // external-clock hold advances only on external clock edges
  assign wt.tick = ((state_q == smsc_pkg::ST_HOLD) & hold_ext) ?
                   ext_clk_tick : 1'b1;

  // entry from run has no latched source yet; take the live one
  // every value read comes in as an argument so the assign tracks it
  function automatic logic [smsc_pkg::CNT_W-1:0] stab_entry_val(
    input logic                            from_run,
    input logic [1:0]                      live_src,
    input logic [1:0]                      held_src,
    input logic [smsc_pkg::CTRL_SEL_W-1:0] live_sel,
    input logic [smsc_pkg::CNT_W-1:0]      held_val
  );
    logic [1:0] s;
    s = from_run ? live_src : held_src;
    if (s != smsc_pkg::SRC_CRYSTAL) begin
      return smsc_pkg::smsc_load(smsc_pkg::NO_STAB_CYC);
    end
    if (from_run) begin
      return stab_sel_val(live_sel);
    end
    return held_val;
  endfunction

  function automatic logic [smsc_pkg::CNT_W-1:0] stab_sel_val(
    input logic [smsc_pkg::CTRL_SEL_W-1:0] sel
  );
    case (sel)
      3'h0:    return smsc_pkg::smsc_load(STAB_CYC_0);
      3'h1:    return smsc_pkg::smsc_load(STAB_CYC_1);
      3'h2:    return smsc_pkg::smsc_load(STAB_CYC_2);
      3'h3:    return smsc_pkg::smsc_load(STAB_CYC_3);
      default: return smsc_pkg::smsc_load(STAB_CYC_4);
    endcase
  endfunction

  smsc_wait_timer u_wait (
    .clk (clk),
    .rst (rst),
    .w   (wt.cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // gate decode

  // cpu clock stays off through stop, stabilization and hold
  assign standby_d = (state_d == smsc_pkg::ST_STOP) |
                     (state_d == smsc_pkg::ST_STAB) |
                     (state_d == smsc_pkg::ST_HOLD);
  assign cpu_clk_en_d = ~standby_d;
  // software may stop the oscillator only when the option allows it
  assign lsosc_run_d = ctrl_q[smsc_pkg::CTRL_LSOSC_BIT] | ~lsosc_sw_stoppable;
  // in standby the oscillator keeps whatever state it had
  assign lsosc_en_d = standby_d ? lsosc_en_q : lsosc_run_d;
  // watchdog loses its clock in standby if the option lets it stop
  assign wdt_clk_en_d = lsosc_en_d &
                        ~(standby_d & lsosc_sw_stoppable);

  smsc_periph_gate u_gate (
    .standby         (standby_d),
    .t50_ext_sel     (t50_ext_sel),
    .t50_running     (t50_running),
    .t51_ext_sel     (t51_ext_sel),
    .ita_t50_sel     (ita_t50_sel),
    .itb_sel         (itb_sel),
    .watch_sub_sel   (watch_sub_sel),
    .clkout_sub_sel  (clkout_sub_sel),
    .lcd_sub_sel     (lcd_sub_sel),
    .async_a_t50_sel (async_a_t50_sel),
    .async_b_t50_sel (async_b_t50_sel),
    .cser_a_ext_sel  (cser_a_ext_sel),
    .cser_b_ext_sel  (cser_b_ext_sel),
    .en              (periph_en_d)
  );

  ////////////////////////////////////////////////////////////////////////
  // register port decode

  assign ctrl_wr = wr_en & (addr == smsc_pkg::ADDR_CTRL);
  assign ctrl_rd = rd_en & (addr == smsc_pkg::ADDR_CTRL);
  assign stat_rd = rd_en & (addr == smsc_pkg::ADDR_STAT);
  // status reflects the sequencer; unused bits read zero
  assign stat_word = {
    {(smsc_pkg::DATA_W - smsc_pkg::STAT_DONE_BIT - 1){1'b0}},
    stab_done_q,
    vec_q,
    state_q == smsc_pkg::ST_HOLD,
    state_q == smsc_pkg::ST_STAB,
    standby_q
  };
  // unmapped reads answer zero
  assign rd_data_d = ctrl_rd ? ctrl_q :
                     stat_rd ? stat_word : smsc_pkg::RD_NONE;

  ////////////////////////////////////////////////////////////////////////
  // state and latches

  // sequencer state; reset ends any stop at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= smsc_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // settings frozen at entry so a late write cannot change the release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amplifier_high_setting_q <= 1'b0;
      src_q  <= smsc_pkg::SRC_INT_HIGH;
      sel_q  <= '0;
    end else if ((state_q == smsc_pkg::ST_RUN) & enter_ok) begin
      amplifier_high_setting_q <= ctrl_q[smsc_pkg::CTRL_AMPLIFIER_HIGH_SETTING_BIT];
      src_q  <= cpu_clk_src;
      sel_q  <= ctrl_q[smsc_pkg::CTRL_SEL_LSB +: smsc_pkg::CTRL_SEL_W];
    end
  end

  // acknowledge decision and stabilization status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_q       <= 1'b0;
      stab_done_q <= 1'b0;
    end else begin
      vec_q       <= vec_d;
      stab_done_q <= ((state_q == smsc_pkg::ST_STAB) & wt.done) |
                     (stab_done_q & ~((state_q == smsc_pkg::ST_RUN) &
                                      enter_ok));
    end
  end

  // control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= smsc_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= wr_data;
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= smsc_pkg::RD_NONE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  // all gates flip on one edge so no peripheral outlives the cpu clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en_q <= 1'b1;
      periph_en_q  <= '1;
      standby_q    <= 1'b0;
    end else begin
      cpu_clk_en_q <= cpu_clk_en_d;
      periph_en_q  <= periph_en_d;
      standby_q    <= standby_d;
    end
  end

  // oscillator and watchdog clock enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lsosc_en_q   <= 1'b1;
      wdt_clk_en_q <= 1'b1;
    end else begin
      lsosc_en_q   <= lsosc_en_d;
      wdt_clk_en_q <= wdt_clk_en_d;
    end
  end

  // one-cycle resume pulses at the end of the post-release wait; reset vector flag high from reset to the first clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_req_q   <= 1'b0;
      next_instr_q   <= 1'b0;
      reset_vector_q <= 1'b1;
    end else begin
      vector_req_q   <= leave_wait & vec_q;
      next_instr_q   <= leave_wait & ~vec_q;
      reset_vector_q <= 1'b0;
    end
  end

endmodule

// ==== test/smsc_cpu_model.sv ====
// cpu and interrupt side model: wake request and external clock ticks
module smsc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       standby_q,
  input  wire logic       ack,
  input  wire logic [9:0] wake_dly,
  output logic            irq,
  output logic            ext_clk_tick
);
  logic [9:0] cnt_q;

  // request after the commanded delay in standby, held until serviced
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 10'h000;
      irq <= 1'b0;
      ext_clk_tick <= 1'b0;
    end else begin
      cnt_q <= standby_q ? cnt_q + 10'h001 : 10'h000;
      ext_clk_tick <= ~ext_clk_tick; // one tick every other cycle
      if (ack)
        irq <= 1'b0;
      else if (standby_q && cnt_q == wake_dly)
        irq <= 1'b1;
    end
  end
endmodule

// ==== test/smsc_properties.sv ====
// port level checks of the stop mode standby controller
module smsc_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        stop_exec,
  input wire logic        cpu_on_main_clock,
  input wire logic [7:0]  int_req,
  input wire logic [7:0]  int_mask,
  input wire logic        lsosc_sw_stoppable,
  input wire logic        t51_ext_sel,
  input wire logic [2:0]  itb_sel,
  input wire logic        cser_a_ext_sel,
  input wire logic        cpu_clk_en_q,
  input wire logic [12:0] periph_en_q,
  input wire logic        lsosc_en_q,
  input wire logic        wdt_clk_en_q,
  input wire logic        standby_q,
  input wire logic        vector_req_q,
  input wire logic        next_instr_q
);
  // any unmasked request wakes the block
  wire wk = |(int_req & ~int_mask);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  stop_entry_a: assert property (stop_exec && cpu_on_main_clock
    && !standby_q && cpu_clk_en_q |=> standby_q && !cpu_clk_en_q
    && !periph_en_q[12]) else $error("stop entry missed");
  stop_refuse_a: assert property (stop_exec && !cpu_on_main_clock
    && !standby_q |=> !standby_q) else $error("stop taken off main clock");
  t51_gate_a: assert property (standby_q |->
    periph_en_q[1] == t51_ext_sel) else $error("timer51 gate wrong");
  itb_gate_a: assert property (standby_q |->
    periph_en_q[3] == (itb_sel >= 3'h5)) else $error("timer b gate wrong");
  cser_gate_a: assert property (standby_q |->
    periph_en_q[9] == cser_a_ext_sel) else $error("serial gate wrong");
  wdt_clock_a: assert property (standby_q |-> wdt_clk_en_q ==
    (lsosc_en_q && !lsosc_sw_stoppable)) else $error("watchdog clock wrong");
  lsosc_keep_a: assert property (standby_q && $past(standby_q)
    |-> $stable(lsosc_en_q)) else $error("oscillator state changed");
  wake_exit_a: assert property (standby_q && wk |->
    ##[1:1000] !standby_q) else $error("wake not taken");
  resume_wait_a: assert property ($fell(standby_q) |-> cpu_clk_en_q
    ##[1:10] (vector_req_q || next_instr_q)) else $error("no resume");
  resume_pulse_a: assert property (vector_req_q || next_instr_q
    |-> !(vector_req_q && next_instr_q) ##1 !vector_req_q && !next_instr_q)
    else $error("resume pulse wrong");
endmodule

// ==== test/tb_top.sv ====
// top testbench for the stop mode standby controller
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr_en, rd_en, stop_exec, irq, tick, rv_q;
  logic        cpu_on_main_clock, int_enable, stoppable, pend_q;
  logic        cpu_clk_en_q, lsosc_en_q, wdt_clk_en_q, standby_q;
  logic        vector_req_q, next_instr_q;
  logic [1:0]  src;
  logic [3:0]  addr;
  logic [7:0]  wr_data, rd_data_q, int_mask, ctl, d;
  logic [9:0]  wake_dly;
  logic [12:0] periph_en_q;
  logic [13:0] rs;
  int          n_checks, miscompares, stab[5] = '{4, 8, 16, 32, 64};

  // short stabilization counts keep the run brief
  stop_mode_standby_control #(.STAB_CYC_0(4), .STAB_CYC_1(8),
    .STAB_CYC_2(16), .STAB_CYC_3(32), .STAB_CYC_4(64))
    u_stop_mode_standby_control (.*, .cpu_clk_src(src), .ext_clk_tick(tick),
    .int_req({pend_q, 6'h00, irq}), .lsosc_sw_stoppable(stoppable),
    .reset_vector_q(rv_q), .t50_ext_sel(rs[0]), .t50_running(rs[1] & rs[0]),
    .t51_ext_sel(rs[2]), .ita_t50_sel(rs[3]), .watch_sub_sel(rs[4]),
    .clkout_sub_sel(rs[5]), .lcd_sub_sel(rs[6]), .async_a_t50_sel(rs[7]),
    .async_b_t50_sel(rs[8]), .cser_a_ext_sel(rs[9]),
    .cser_b_ext_sel(rs[10]), .itb_sel(rs[13:11]));
  smsc_cpu_model u_smsc_cpu_model (.clk(clk), .rst(rst),
    .standby_q(standby_q), .ack(vector_req_q | next_instr_q),
    .wake_dly(wake_dly), .irq(irq), .ext_clk_tick(tick));

  ////////////////////////////////////////////////////////////////////////
  // gates expected in stop; timer50 counts as running only on its pin
  function automatic logic [12:0] exp_gate(logic [13:0] r);
    return {2'b00, r[10:9], r[8] & r[1] & r[0], r[7] & r[1] & r[0], r[6:4],
      r[13:11] >= 3'h5, r[3] & r[1] & r[0], r[2], r[0]};
  endfunction
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data_q;
  endtask
  task automatic run_stop(bit msk);
    int off, w, k, n, h;
    int_mask <= {7'h3F, msk};
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    #1 `CHK("standby", 1'b1, standby_q)
    `CHK("gates", exp_gate(rs), periph_en_q)
    `CHK("lsosc", ctl[4] | ~stoppable, lsosc_en_q)
    `CHK("wdt", ~stoppable, wdt_clk_en_q)
    if (msk) begin
      repeat (40) @(posedge clk);
      rd(4'h4);
      `CHK("held", 1'b1, d[0])
      @(posedge clk);
      int_mask <= 8'h7E;
    end
    off = 1;
    w = 0;
    for (k = 0; k < 3000 && !(vector_req_q | next_instr_q); k++) begin
      @(posedge clk);
      #1 off += !cpu_clk_en_q;
      w += !standby_q;
    end
    if (k == 3000) begin
      miscompares++;
      end_of_test();
    end
    // stabilization only on crystal; hold only with amplifier high
    n = src == 2'h1 ? stab[ctl[2:0] > 4 ? 4 : ctl[2:0]] : 1;
    h = !ctl[3] ? 0 : src == 2'h0 ? smsc_pkg::HOLD_INT_CYC :
      src == 2'h2 ? 2 * smsc_pkg::HOLD_EXT_CLKS : 0;
    k = wake_dly + n + h;
    if (!msk && !pend_q)
      `CHK("off", 1'b1, off >= k - 1 && off <= k + 5)
    k = int_enable ? 8 : 2;
    `CHK("wait", 1'b1, w >= k && w <= k + 3)
    `CHK("vector", int_enable, vector_req_q)
    `CHK("next", !int_enable, next_instr_q)
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst, wr_en, rd_en, stop_exec, pend_q, stoppable} = 6'b100000;
    {cpu_on_main_clock, int_enable, src, addr, wr_data, ctl, rs} = '0;
    int_mask = 8'h7E;
    wake_dly = 10'd5;
    n_checks = 0;
    miscompares = 0;
    void'($urandom(96));
    repeat (2) @(posedge clk);
    #1 `CHK("rstvec", 1'b1, rv_q)
    @(posedge clk);
    rst <= 1'b0;
    rd(4'h0);
    `CHK("ctrl", 8'h10, d)
    rd(4'h9);
    `CHK("unmapped", 8'h00, d)
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    #1 `CHK("refused", 1'b0, standby_q)
    @(posedge clk);
    cpu_on_main_clock <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      rs <= 14'($urandom);
      src <= 2'(i % 3);
      int_enable <= 1'($urandom);
      stoppable <= 1'($urandom);
      pend_q <= i == 2;
      ctl = 8'($urandom) & 8'h1F | (i > 3 ? 8'h08 : 8'h00);
      wr(4'h0, ctl);
      run_stop(i == 1);
    end
    // reset in the middle of a stop
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    #1 `CHK("rst_stop", 1'b0, standby_q)
    `CHK("rst_vec", 1'b1, rv_q)
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 `CHK("rst_rel", 1'b0, rv_q)
    end_of_test();
  end
endmodule
bind stop_mode_standby_control smsc_properties u_smsc_properties (.*);
